// >>> hdl/pwmwta_pkg.sv
`default_nettype none
package pwmwta_pkg;
    // ==========================================================
    // Geometry
    localparam int CH_N      = 8;
    localparam int WIDTH_W   = 12;
    localparam int K_W       = 3;
    localparam int CFG1_BITS = CH_N * WIDTH_W;   // 96-bit width stream
    localparam int CFG2_BITS = CH_N + K_W;       // switch field then K
    localparam int RD2_BITS  = 2 * CH_N;         // nearest then K-smallest
    // ==========================================================
    // Reset values and counter limit
    localparam logic [11:0] WIDTH_RST  = 12'h000;
    localparam logic [7:0]  SWITCH_RST = 8'h00;
    localparam logic [2:0]  K_RST      = 3'h1;
    localparam logic [11:0] CNT_MAX    = 12'hFFF;
endpackage
`default_nettype wire

// >>> hdl/pwmwta_top.sv
`timescale 1ns/1ps
`default_nettype none
module pwmwta_top #(
    parameter int CH_N    = pwmwta_pkg::CH_N,
    parameter int WIDTH_W = pwmwta_pkg::WIDTH_W
) (
    // Clock and reset
    input  wire logic          CLK_SYS,
    input  wire logic          ARST_N,
    // Port one: widths in, durations out
    input  wire logic          SER1_SEL_N,
    input  wire logic          SER1_DIN,
    output logic               SER1_DOUT,
    // Port two: switches and K in, addresses out
    input  wire logic          SER2_SEL_N,
    input  wire logic          SER2_DIN,
    output logic               SER2_DOUT,
    // Trigger (user input bit 4) and external PWM
    input  wire logic          PWM_TRIGGER,
    input  wire logic [CH_N-1:0] EXT_PWM,
    // Observation of channels 0 and 7
    output logic               CH0_RAW,
    output logic               CH0_SYNC,
    output logic               CH0_FALL,
    output logic               CH7_RAW,
    output logic               CH7_SYNC,
    output logic               CH7_FALL
);
    localparam int C1 = CH_N * WIDTH_W;
    localparam int C2 = CH_N + pwmwta_pkg::K_W;

    // ==========================================================
    // Configuration and readout shift registers
    logic [C1-1:0]      cfg1_r;
    logic [C2-1:0]      cfg2_r;
    logic [C1-1:0]      rd1_r;
    logic [2*CH_N-1:0]  rd2_r;
    logic               sel1_q_r;
    logic               sel2_q_r;
    logic [CH_N-1:0]    sw_r;
    logic [2:0]         k_r;
    logic [C1-1:0]      dur_flat;
    logic [CH_N-1:0]    nearest_result_r;
    logic [CH_N-1:0]    kth_r;

    // Select falling edge starts a frame: reload readout on that edge
    wire start1 = !SER1_SEL_N && sel1_q_r;
    wire start2 = !SER2_SEL_N && sel2_q_r;
    wire end2   = SER2_SEL_N && !sel2_q_r;

    // Shifting on system clock while select is low, MSB-first stream.
    // Top bit leaves combinationally in the first cycle, so the snapshot is stored pre-shifted
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            cfg1_r   <= '0;
            cfg2_r   <= '0;
            rd1_r    <= '0;
            rd2_r    <= '0;
            sel1_q_r <= 1'b1;
            sel2_q_r <= 1'b1;
        end else begin
            sel1_q_r <= SER1_SEL_N;
            sel2_q_r <= SER2_SEL_N;
            if (!SER1_SEL_N) begin
                cfg1_r <= {cfg1_r[C1-2:0], SER1_DIN};
                rd1_r  <= start1 ? {dur_flat[C1-2:0], 1'b0} : {rd1_r[C1-2:0], 1'b0};
            end
            if (!SER2_SEL_N) begin
                cfg2_r <= {cfg2_r[C2-2:0], SER2_DIN};
                rd2_r  <= start2 ? {nearest_result_r[CH_N-2:0], kth_r, 1'b0} : {rd2_r[2*CH_N-2:0], 1'b0};
            end
        end
    end

    // First bit out is the MSB of the loaded image; channel 0 sits on top of the durations, channel 7 on top of each address byte
    assign SER1_DOUT = start1 ? dur_flat[C1-1] : rd1_r[C1-1];
    assign SER2_DOUT = start2 ? nearest_result_r[CH_N-1] : rd2_r[2*CH_N-1];

    // Switches and K take effect when port two closes
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            sw_r <= pwmwta_pkg::SWITCH_RST;
            k_r  <= pwmwta_pkg::K_RST;
        end else if (end2) begin
            sw_r <= cfg2_r[C2-1:pwmwta_pkg::K_W];
            k_r  <= cfg2_r[pwmwta_pkg::K_W-1:0];
        end
    end

    // ==========================================================
    // Shared trigger and cycle counter
    logic               trig_q_r;
    logic               run_r;
    logic [WIDTH_W-1:0] cnt_r;
    wire  trig_rise = PWM_TRIGGER && !trig_q_r;

    // Counter saturates so a run can never restart a pulse by itself
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            trig_q_r <= 1'b0;
            run_r    <= 1'b0;
            cnt_r    <= '0;
        end else begin
            trig_q_r <= PWM_TRIGGER;
            if (trig_rise) begin
                run_r <= 1'b1;
                cnt_r <= '0;
            end else if (run_r) begin
                if (cnt_r == WIDTH_W'(pwmwta_pkg::CNT_MAX))
                    run_r <= 1'b0;
                else
                    cnt_r <= cnt_r + 1'b1;
            end
        end
    end

    // ==========================================================
    // Per-channel generator, selection, sync, edge and duration
    logic [CH_N-1:0] raw;
    logic [CH_N-1:0] sync2;
    logic [CH_N-1:0] fall;
    logic [CH_N-1:0] fall_reg_r;

    genvar g;
    generate
        for (g = 0; g < CH_N; g++) begin : gen_ch
            logic               gen_r;
            logic               s1_r;
            logic               s2_r;
            logic               s3_r;
            logic [WIDTH_W-1:0] dur_r;
            // Channel 0 is the most significant word of the stream
            wire  [WIDTH_W-1:0] width = cfg1_r[C1-1-g*WIDTH_W -: WIDTH_W];
            // Counter is seen one cycle late, so stop one count early: pulse is width cycles long
            wire                last_cnt = ({1'b0, cnt_r} + 1'b1) >= {1'b0, width};

            always_ff @(posedge CLK_SYS or negedge ARST_N) begin
                if (!ARST_N) begin
                    gen_r <= 1'b0;
                end else if (trig_rise) begin
                    gen_r <= (width != '0);
                end else if (last_cnt) begin
                    gen_r <= 1'b0;
                end
            end

            assign raw[g] = sw_r[g] ? EXT_PWM[g] : gen_r;

            // s1 feeds only s2; edge logic looks at s2 and s3
            always_ff @(posedge CLK_SYS or negedge ARST_N) begin
                if (!ARST_N) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                end else begin
                    s1_r <= raw[g];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                end
            end
            assign sync2[g] = s2_r;
            assign fall[g]  = s3_r && !s2_r;

            // Duration counts synchronised high cycles, saturating
            always_ff @(posedge CLK_SYS or negedge ARST_N) begin
                if (!ARST_N) begin
                    dur_r <= '0;
                end else if (trig_rise) begin
                    dur_r <= '0;
                end else if (s2_r && dur_r != '1) begin
                    dur_r <= dur_r + 1'b1;
                end
            end
            assign dur_flat[C1-1-g*WIDTH_W -: WIDTH_W] = dur_r;
        end
    endgenerate

    // ==========================================================
    // Winner selection
    wire [CH_N-1:0] fall_all = fall_reg_r | fall;
    logic [3:0] pop;
    always_comb begin
        pop = '0;
        for (int i = 0; i < CH_N; i++)
            pop = pop + 4'(fall_all[i]);
    end

    // Results cleared on trigger; ties on the first edge all win
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            fall_reg_r       <= '0;
            nearest_result_r <= '0;
            kth_r            <= '0;
        end else if (trig_rise) begin
            fall_reg_r       <= '0;
            nearest_result_r <= '0;
            kth_r            <= '0;
        end else begin
            fall_reg_r <= fall_all;
            if (fall_reg_r == '0 && fall != '0)
                nearest_result_r <= fall;
            if (kth_r == '0 && k_r != '0 && pop >= {1'b0, k_r})
                kth_r <= fall_all;
        end
    end

    // Observation taps
    assign CH0_RAW  = raw[0];
    assign CH0_SYNC = sync2[0];
    assign CH0_FALL = fall[0];
    assign CH7_RAW  = raw[CH_N-1];
    assign CH7_SYNC = sync2[CH_N-1];
    assign CH7_FALL = fall[CH_N-1];
endmodule
`default_nettype wire

// >>> test/pwmwta_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Checks on the channel 0 and 7 taps
module pwmwta_asserts (
    // Clock and reset
    input  wire logic CLK_SYS,
    input  wire logic ARST_N,
    // Channel taps
    input  wire logic CH0_RAW,
    input  wire logic CH0_SYNC,
    input  wire logic CH0_FALL,
    input  wire logic CH7_RAW,
    input  wire logic CH7_SYNC,
    input  wire logic CH7_FALL
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);
    // Fall windows allow a pulse in the drop cycle or one cycle later
    a_sync0_lag: assert property (CH0_SYNC == $past(CH0_RAW, 2)) else $error("ch0 sync lag wrong");
    a_sync7_lag: assert property (CH7_SYNC == $past(CH7_RAW, 2)) else $error("ch7 sync lag wrong");
    a_fall0_seen: assert property ($fell(CH0_SYNC) |-> ##[0:1] CH0_FALL) else $error("ch0 fall lost");
    a_fall7_seen: assert property ($fell(CH7_SYNC) |-> ##[0:1] CH7_FALL) else $error("ch7 fall lost");
    a_fall0_one: assert property (CH0_FALL |=> !CH0_FALL) else $error("ch0 fall too long");
    a_fall7_one: assert property (CH7_FALL |=> !CH7_FALL) else $error("ch7 fall too long");
    a_fall0_low: assert property (CH0_FALL |-> !CH0_SYNC) else $error("ch0 fall while high");
    a_fall7_low: assert property (CH7_FALL |-> !CH7_SYNC) else $error("ch7 fall while high");
endmodule
bind pwmwta_top pwmwta_asserts u_chk (
    .CLK_SYS  (CLK_SYS),
    .ARST_N   (ARST_N),
    .CH0_RAW  (CH0_RAW),
    .CH0_SYNC (CH0_SYNC),
    .CH0_FALL (CH0_FALL),
    .CH7_RAW  (CH7_RAW),
    .CH7_SYNC (CH7_SYNC),
    .CH7_FALL (CH7_FALL)
);
`default_nettype wire

// >>> test/pwmwta_host.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Host model: two serial ports, trigger, external PWM
module pwmwta_host (
    // Clock
    input  wire logic      clk,
    // Serial ports
    output var  logic      sel1_n,
    output var  logic      sel2_n,
    output var  logic      din,
    input  wire logic      dout1,
    input  wire logic      dout2,
    // Run control
    output var  logic      trig,
    output var  logic [7:0] ext
);
    logic [95:0] rd;
    int          rd_n;
    event        got;
    // Idle levels at time zero
    initial begin
        sel1_n = 1'b1;
        sel2_n = 1'b1;
        din = 1'b0;
        trig = 1'b0;
        ext = 8'h00;
    end
    // One frame, MSB first; shared data line keeps toggling on the idle port
    task automatic frame(input int p, input int n, input logic [95:0] v);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk);
            sel1_n <= (p != 1);
            sel2_n <= (p != 2);
            din <= v[i];
            @(negedge clk);
            rd[i] = (p == 1) ? dout1 : dout2;
        end
        @(posedge clk);
        sel1_n <= 1'b1;
        sel2_n <= 1'b1;
        rd_n = n;
        ->got;
    endtask
    // External pulses start with the internal ones, one edge after trigger
    task automatic fire(input logic [95:0] e);
        @(posedge clk);
        trig <= 1'b1;
        @(posedge clk);
        for (int c = 0; c < 8; c++)
            ext[c] <= (e[95-12*c -: 12] != 12'h000);
        for (int t = 1; t < 4100; t++) begin
            @(posedge clk);
            for (int c = 0; c < 8; c++)
                if (e[95-12*c -: 12] == t[11:0])
                    ext[c] <= 1'b0;
        end
        trig <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> test/pwmwta_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Bench top
module pwmwta_tb;
    logic        clk_sys, arst_n, sel1_n, sel2_n, din, dout1, dout2, trig;
    logic [7:0]  ext, sw;
    logic [95:0] w, e, m, exp_q[$];
    int          error_cnt, n_tests, cyc;
    pwmwta_top dut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .SER1_SEL_N(sel1_n), .SER1_DIN(din), .SER1_DOUT(dout1),
        .SER2_SEL_N(sel2_n), .SER2_DIN(din), .SER2_DOUT(dout2), .PWM_TRIGGER(trig), .EXT_PWM(ext),
        .CH0_RAW(), .CH0_SYNC(), .CH0_FALL(), .CH7_RAW(), .CH7_SYNC(), .CH7_FALL());
    pwmwta_host host (.clk(clk_sys), .sel1_n(sel1_n), .sel2_n(sel2_n), .din(din), .dout1(dout1),
        .dout2(dout2), .trig(trig), .ext(ext));
    // Odd runs use tiny widths so ties and zero widths show up
    function automatic logic [95:0] rnd(input int r);
        logic [95:0] v;
        for (int c = 0; c < 8; c++)
            v[95-12*c -: 12] = r[0] ? 12'($urandom % 6) : 12'($urandom);
        return v;
    endfunction
    // First fallers, and the fallen set once the count reaches k
    function automatic logic [95:0] adr(input logic [95:0] v, input logic [2:0] k);
        logic [7:0] nn, kn, f, s;
        int n;
        nn = 8'h00;
        kn = 8'h00;
        for (int t = 1; t < 4096; t++) begin
            n = 0;
            for (int c = 0; c < 8; c++) begin
                f[c] = (v[95-12*c -: 12] == t[11:0]);
                s[c] = (v[95-12*c -: 12] != 12'h000) && (v[95-12*c -: 12] <= t[11:0]);
                n += int'(s[c]);
            end
            if (nn == 8'h00)
                nn = f;
            if (k != 3'h0 && kn == 8'h00 && n >= int'(k))
                kn = s;
        end
        return {80'h0, nn, kn};
    endfunction
    task chk_dur(input logic [95:0] x);
        n_tests++;
        if (host.rd !== x) begin
            error_cnt++;
            $display("unexpected %0t durations %h want %h", $time, host.rd, x);
        end
    endtask
    task chk_adr(input logic [95:0] x);
        n_tests++;
        if (host.rd[15:0] !== x[15:0]) begin
            error_cnt++;
            $display("unexpected %0t addresses %h want %h", $time, host.rd[15:0], x[15:0]);
        end
    endtask
    task results();
        $display("errors %0d of %0d checks", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Watcher takes the oldest note for each finished readout
    always @(host.got) begin
        if (host.rd_n == 96)
            chk_dur(exp_q.pop_front());
        else if (host.rd_n == 16)
            chk_adr(exp_q.pop_front());
    end
    // Clock and hang guard
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            results();
        end
    end
    // Reset, then one run per K; each duration readout also loads the next widths
    initial begin
        arst_n = 1'b0;
        void'($urandom(32'h6802));
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        w = rnd(0);
        exp_q.push_back(96'h0);
        host.frame(1, 96, w);
        for (int r = 0; r < 8; r++) begin
            sw = 8'($urandom);
            e = rnd(r);
            for (int c = 0; c < 8; c++)
                m[95-12*c -: 12] = sw[c] ? e[95-12*c -: 12] : w[95-12*c -: 12];
            host.frame(2, 11, {85'h0, sw, r[2:0]});
            host.fire(e);
            exp_q.push_back(m);
            exp_q.push_back(adr(m, r[2:0]));
            w = rnd(r + 1);
            host.frame(1, 96, w);
            host.frame(2, 16, 96'h0);
        end
        // Let the watcher finish the last readout before the verdict
        @(posedge clk_sys);
        results();
    end
endmodule
`default_nettype wire
